// ==== design/hub_power_pkg.sv ====
// Contract
// - Controller reads the captured line states for the host's bus-state request.
// - Hardware sets change flags except bit 3 and Port 1 bit 2; controller only clears them.
// - Controller sets overcurrent-change bit 3 on a per-port fault; Port 1 keeps it 0.
// - Controller sets Port 1 suspend-change 20 ms after the EOF2 following resume.
// - Global mode senses on D0 and enables its suspend detection.
// - Per-port mode senses Port 2 on D0 and Port 3 on D1.
// - Global fault sets hub indicator and change, powers all ports off.
// - Per-port fault sets that port's indicator and change, powers it off.
// - Ganged switch turns off only when both port power bits are clear.
// - Individual switching drives one control output per port from its bit.
package hub_power_pkg;

  localparam int unsigned DEV_AW = 13;

  localparam logic [DEV_AW-1:0] PORT2_LINE_STATE_ADDR = 13'h1FA9;
  localparam logic [DEV_AW-1:0] PORT3_LINE_STATE_ADDR = 13'h1FAA;
  localparam logic [DEV_AW-1:0] PORT1_CHANGE_ADDR     = 13'h1FB0;
  localparam logic [DEV_AW-1:0] PORT2_CHANGE_ADDR     = 13'h1FB1;
  localparam logic [DEV_AW-1:0] PORT3_CHANGE_ADDR     = 13'h1FB2;
  localparam logic [DEV_AW-1:0] SUSP_OC_ENABLE_ADDR   = 13'h1FF2;

  localparam logic [7:0] CHANGE_FLAGS_MASK   = 8'h1F;
  localparam logic [7:0] OC_CHANGE_MASK      = 8'h08;
  localparam logic [7:0] SUSPEND_CHANGE_MASK = 8'h04;
  localparam logic [7:0] SENSE_A_ENABLE_MASK = 8'h04;
  localparam logic [7:0] SENSE_B_ENABLE_MASK = 8'h08;
  localparam logic [7:0] LINE_STATE_MASK     = 8'h03;
  localparam logic [1:0] PORT1_LINE_STATE    = 2'h2;
  localparam logic [2:0] PIN_IDLE            = 3'h3;

  // Own register map, one 32-bit word each.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] CMD_OFFSET    = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  localparam int unsigned CTRL_PER_PORT   = 0;
  localparam int unsigned CTRL_INDIVIDUAL = 1;
  localparam int unsigned CTRL_PORT2_PWR  = 2;
  localparam int unsigned CTRL_PORT3_PWR  = 3;
  localparam int unsigned CTRL_SUSPENDED  = 4;
  localparam logic [4:0]  CTRL_MASK       = 5'h1F;

  localparam int unsigned CMD_PORT_LSB   = 0;
  localparam int unsigned CMD_MASK_LSB   = 8;
  localparam int unsigned CMD_CLEAR      = 16;
  localparam int unsigned CMD_CAPTURE    = 17;
  localparam int unsigned CMD_P1_RESUMED = 18;
  localparam int unsigned CMD_HUB_OC_ACK = 19;
  localparam int unsigned CMD_OC_RELEASE = 20;

  localparam longint unsigned CLK_HZ          = 50_000_000;
  localparam longint unsigned RESUME_DELAY_MS = 20;
  localparam int unsigned RESUME_DELAY_CYCLES = int'(RESUME_DELAY_MS * CLK_HZ / 1000);

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_READ  = 2'b01,
    SEQ_WAIT  = 2'b11,
    SEQ_WRITE = 2'b10
  } seq_state_t;

  // Job index doubles as priority: lowest pending index runs first.
  localparam int unsigned JOB_N       = 7;
  localparam int unsigned JOB_SUSP_EN = 0;
  localparam int unsigned JOB_OC2     = 1;
  localparam int unsigned JOB_OC3     = 2;
  localparam int unsigned JOB_P1_SSC  = 3;
  localparam int unsigned JOB_CLEAR   = 4;
  localparam int unsigned JOB_CAP2    = 5;
  localparam int unsigned JOB_CAP3    = 6;

  typedef struct packed {
    logic [DEV_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } dev_req_t;

endpackage

// ==== design/hub_power_manager.sv ====
`timescale 1ns/1ns
module hub_power_manager
  import hub_power_pkg::*;
#(
  parameter int unsigned RESUME_DELAY = RESUME_DELAY_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output dev_req_t         dev_req,
  input  wire logic [7:0]  dev_rdata,
  input  wire logic        general_input_d0,
  input  wire logic        general_input_d1,
  input  wire logic        eof2_marker,
  output logic             shared_power_switch_control_n,
  output logic             port2_power_switch_control_n,
  output logic             port3_power_switch_control_n
);

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] stable;
  logic [2:0] next_stable;
  logic [2:0] fall;
  logic [2:0] rise;

  assign pin_raw = {eof2_marker, general_input_d1, general_input_d0};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      assign next_stable[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : stable[gi];
      assign fall[gi]        = stable[gi] & ~next_stable[gi];
      assign rise[gi]        = ~stable[gi] & next_stable[gi];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1[gi]  <= PIN_IDLE[gi];
          sync2[gi]  <= PIN_IDLE[gi];
          sync3[gi]  <= PIN_IDLE[gi];
          stable[gi] <= PIN_IDLE[gi];
        end else begin
          sync1[gi]  <= pin_raw[gi];
          sync2[gi]  <= sync1[gi];
          sync3[gi]  <= sync2[gi];
          stable[gi] <= next_stable[gi];
        end
      end
    end
  endgenerate

  logic [4:0]  ctrl;
  logic        hub_oc_ind;
  logic        hub_oc_chg;
  logic [1:0]  port_oc_ind;
  logic [1:0]  line2;
  logic [1:0]  line3;
  logic [JOB_N-1:0] pend;
  logic [1:0]  clr_port;
  logic [7:0]  clr_mask;

  wire per_port   = ctrl[CTRL_PER_PORT];
  wire individual = ctrl[CTRL_INDIVIDUAL];
  wire oc_global  = ~per_port & fall[0];
  wire oc_port2   = per_port & fall[0];
  wire oc_port3   = per_port & fall[1];

  // AXI4-Lite slave: address and data are taken together in one cycle.
  wire wr_fire  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire rd_fire  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire wr_take  = s_axi_awready;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wbits = s_axi_wdata & wmask;
  wire ctrl_hit = s_axi_awaddr == CTRL_OFFSET;
  wire cmd_hit  = s_axi_awaddr == CMD_OFFSET;
  wire wr_ok    = ctrl_hit | cmd_hit;
  wire ctrl_wr  = wr_take & ctrl_hit;
  wire cmd_wr   = wr_take & cmd_hit;
  wire cmd_clear    = cmd_wr & wbits[CMD_CLEAR] & ~pend[JOB_CLEAR];
  wire cmd_capture  = cmd_wr & wbits[CMD_CAPTURE];
  wire cmd_p1_res   = cmd_wr & wbits[CMD_P1_RESUMED];
  wire cmd_hub_ack  = cmd_wr & wbits[CMD_HUB_OC_ACK];
  wire cmd_oc_rel   = cmd_wr & wbits[CMD_OC_RELEASE];

  // Software power bits; a fault switches power off and wins over a write.
  wire [4:0] ctrl_written = ctrl_wr ? (wbits[4:0] & CTRL_MASK) : ctrl;
  wire pwr2_off = oc_global | oc_port2;
  wire pwr3_off = oc_global | oc_port3;
  wire [4:0] next_ctrl = {ctrl_written[4],
                          ctrl_written[CTRL_PORT3_PWR] & ~pwr3_off,
                          ctrl_written[CTRL_PORT2_PWR] & ~pwr2_off,
                          ctrl_written[1:0]};

  wire [31:0] status_word = {21'h0, |pend, port_oc_ind, hub_oc_chg, hub_oc_ind,
                             PORT1_LINE_STATE, line3, line2};
  wire [31:0] rd_word = (s_axi_araddr == CTRL_OFFSET)   ? {27'h0, ctrl} :
                        (s_axi_araddr == STATUS_OFFSET) ? status_word : 32'h0;
  wire rd_ok = (s_axi_araddr == CTRL_OFFSET) | (s_axi_araddr == STATUS_OFFSET) |
               (s_axi_araddr == CMD_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rd_fire;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Overcurrent indicators: a fault wins over the acknowledge in the same cycle.
  wire       next_hub_oc_ind = oc_global | (hub_oc_ind & ~cmd_oc_rel);
  wire       next_hub_oc_chg = oc_global | (hub_oc_chg & ~cmd_hub_ack);
  wire [1:0] next_port_oc    = {oc_port3, oc_port2} | (port_oc_ind & ~{2{cmd_oc_rel}});

  // Suspend-detect enables that the device should hold right now.
  wire [7:0] susp_en_want = ~ctrl[CTRL_SUSPENDED] ? 8'h00 :
                            per_port ? (SENSE_A_ENABLE_MASK | SENSE_B_ENABLE_MASK) :
                            SENSE_A_ENABLE_MASK;
  logic [7:0] susp_en_sent;

  // Port 1 suspend-change timing: wait for EOF2, then count the delay.
  logic        p1_wait_eof;
  logic        p1_counting;
  logic [31:0] p1_count;
  wire p1_start = p1_wait_eof & rise[2];
  wire p1_done  = p1_counting & (p1_count == RESUME_DELAY - 1);

  // Sequencer over the device register interface.
  seq_state_t state;
  logic [JOB_N-1:0] job;

  logic [JOB_N-1:0] pick;
  always_comb begin
    pick = '0;
    for (int i = JOB_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

  wire idle_take = (state == SEQ_IDLE) & (|pend);
  // A clear arriving while a clear job runs would change its mask mid-way.
  wire clr_take  = cmd_clear & ~(job[JOB_CLEAR] & (state != SEQ_IDLE));
  wire [JOB_N-1:0] taken = idle_take ? pick : '0;
  wire [JOB_N-1:0] sets;
  assign sets[JOB_SUSP_EN] = (susp_en_want != susp_en_sent) & ~(idle_take & pick[JOB_SUSP_EN]);
  assign sets[JOB_OC2]     = oc_port2;
  assign sets[JOB_OC3]     = oc_port3;
  assign sets[JOB_P1_SSC]  = p1_done;
  assign sets[JOB_CLEAR]   = clr_take;
  assign sets[JOB_CAP2]    = cmd_capture;
  assign sets[JOB_CAP3]    = cmd_capture;
  wire [JOB_N-1:0] next_pend = (pend & ~taken) | sets;

  wire [DEV_AW-1:0] pick_addr =
    pick[JOB_SUSP_EN] ? SUSP_OC_ENABLE_ADDR :
    pick[JOB_OC2]     ? PORT2_CHANGE_ADDR :
    pick[JOB_OC3]     ? PORT3_CHANGE_ADDR :
    pick[JOB_P1_SSC]  ? PORT1_CHANGE_ADDR :
    pick[JOB_CAP2]    ? PORT2_LINE_STATE_ADDR :
    pick[JOB_CAP3]    ? PORT3_LINE_STATE_ADDR :
    (clr_port == 2'h1) ? PORT1_CHANGE_ADDR :
    (clr_port == 2'h2) ? PORT2_CHANGE_ADDR : PORT3_CHANGE_ADDR;

  // Read-modify-write only clears the masked bits or adds the firmware-owned ones.
  // A hardware set landing between the read and the write can be lost; the
  // window is two cycles and is the price of a byte-wide device port.
  wire        p1_target = job[JOB_P1_SSC] | (job[JOB_CLEAR] & (clr_port == 2'h1));
  wire [7:0]  rmw_or    = (job[JOB_OC2] | job[JOB_OC3]) ? OC_CHANGE_MASK :
                          job[JOB_P1_SSC] ? SUSPEND_CHANGE_MASK : 8'h00;
  wire [7:0]  rmw_and   = (job[JOB_CLEAR] ? ~clr_mask : 8'hFF) &
                          (p1_target ? ~OC_CHANGE_MASK : 8'hFF);
  wire [7:0]  rmw_data  = ((dev_rdata | rmw_or) & rmw_and) & CHANGE_FLAGS_MASK;
  wire        is_cap    = job[JOB_CAP2] | job[JOB_CAP3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= 5'h0;
      hub_oc_ind   <= 1'b0;
      hub_oc_chg   <= 1'b0;
      port_oc_ind  <= 2'h0;
      pend         <= '0;
      clr_port     <= 2'h0;
      clr_mask     <= 8'h0;
      susp_en_sent <= 8'h0;
      p1_wait_eof  <= 1'b0;
      p1_counting  <= 1'b0;
      p1_count     <= 32'h0;
      state        <= SEQ_IDLE;
      job          <= '0;
      line2        <= 2'h0;
      line3        <= 2'h0;
      dev_req      <= '0;
    end else begin
      ctrl        <= next_ctrl;
      hub_oc_ind  <= next_hub_oc_ind;
      hub_oc_chg  <= next_hub_oc_chg;
      port_oc_ind <= next_port_oc;
      pend        <= next_pend;
      if (clr_take) begin
        clr_port <= wbits[CMD_PORT_LSB +: 2];
        clr_mask <= wbits[CMD_MASK_LSB +: 8] & CHANGE_FLAGS_MASK;
      end
      if (cmd_p1_res) begin
        p1_wait_eof <= 1'b1;
      end else if (p1_start) begin
        p1_wait_eof <= 1'b0;
      end
      if (p1_start) begin
        p1_counting <= 1'b1;
        p1_count    <= 32'h0;
      end else if (p1_done) begin
        p1_counting <= 1'b0;
      end else if (p1_counting) begin
        p1_count <= p1_count + 32'h1;
      end
      dev_req.rd <= 1'b0;
      dev_req.wr <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          if (|pend) begin
            job          <= pick;
            dev_req.addr <= pick_addr;
            if (pick[JOB_SUSP_EN]) begin
              dev_req.wr    <= 1'b1;
              dev_req.wdata <= susp_en_want;
              susp_en_sent  <= susp_en_want;
              state         <= SEQ_WRITE;
            end else begin
              dev_req.rd <= 1'b1;
              state      <= SEQ_READ;
            end
          end
        end
        SEQ_READ: begin
          state <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (job[JOB_CAP2]) begin
            line2 <= dev_rdata[1:0] & LINE_STATE_MASK[1:0];
          end
          if (job[JOB_CAP3]) begin
            line3 <= dev_rdata[1:0] & LINE_STATE_MASK[1:0];
          end
          if (is_cap) begin
            state <= SEQ_IDLE;
          end else begin
            dev_req.wr    <= 1'b1;
            dev_req.wdata <= rmw_data;
            state         <= SEQ_WRITE;
          end
        end
        SEQ_WRITE: begin
          state <= SEQ_IDLE;
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Power switch pins are active low and follow the software power bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_power_switch_control_n <= 1'b1;
      port2_power_switch_control_n  <= 1'b1;
      port3_power_switch_control_n  <= 1'b1;
    end else begin
      shared_power_switch_control_n <= individual |
                                       ~(ctrl[CTRL_PORT2_PWR] | ctrl[CTRL_PORT3_PWR]);
      port2_power_switch_control_n  <= ~individual | ~ctrl[CTRL_PORT2_PWR];
      port3_power_switch_control_n  <= ~individual | ~ctrl[CTRL_PORT3_PWR];
    end
  end

endmodule

// ==== sim/hub_power_manager_asserts.sv ====
`timescale 1ns/1ns
module hub_power_manager_asserts
  import hub_power_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire dev_req_t    dev_req,
  input wire logic        shared_power_switch_control_n,
  input wire logic        port2_power_switch_control_n,
  input wire logic        port3_power_switch_control_n
);
  wire flag_rd  = dev_req.rd && (dev_req.addr == PORT2_CHANGE_ADDR || dev_req.addr == PORT3_CHANGE_ADDR);
  wire port1_wr = dev_req.wr && dev_req.addr == PORT1_CHANGE_ADDR;
  wire susp_wr  = dev_req.wr && dev_req.addr == SUSP_OC_ENABLE_ADDR;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_aw_w_pair;
    s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid;
  endproperty
  a_aw_w_pair: assert property (p_aw_w_pair) else $error("write address and data not taken together");
  property p_b_follows;
    s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_b_follows: assert property (p_b_follows) else $error("write response late");
  property p_b_holds;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_holds: assert property (p_b_holds) else $error("write response dropped");
  property p_r_follows;
    s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_follows: assert property (p_r_follows) else $error("read data late");
  property p_r_holds;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_holds: assert property (p_r_holds) else $error("read data dropped");
  property p_one_switch_mode;
    !shared_power_switch_control_n |-> port2_power_switch_control_n && port3_power_switch_control_n;
  endproperty
  a_one_switch_mode: assert property (p_one_switch_mode) else $error("ganged and port switches both on");
  property p_rmw;
    flag_rd |=> !dev_req.wr ##1 dev_req.wr && $stable(dev_req.addr);
  endproperty
  a_rmw: assert property (p_rmw) else $error("change flag read not written back");
  property p_port1_oc;
    port1_wr |-> !dev_req.wdata[3];
  endproperty
  a_port1_oc: assert property (p_port1_oc) else $error("port 1 overcurrent change written");
  property p_susp_code;
    susp_wr |-> dev_req.wdata inside {8'h00, 8'h04, 8'h0C};
  endproperty
  a_susp_code: assert property (p_susp_code) else $error("bad suspend sense enable value");
  property p_ro_lines;
    dev_req.wr |-> dev_req.addr != PORT2_LINE_STATE_ADDR && dev_req.addr != PORT3_LINE_STATE_ADDR;
  endproperty
  a_ro_lines: assert property (p_ro_lines) else $error("write to line state register");
endmodule

bind hub_power_manager hub_power_manager_asserts u_asserts (.*);

// ==== sim/hub_device_model.sv ====
`timescale 1ns/1ns
module hub_device_model
  import hub_power_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire dev_req_t   dev_req,
  input  wire logic [1:0] port2_lines,
  input  wire logic [1:0] port3_lines,
  input  wire logic       frame_end,
  output logic [7:0]      dev_rdata,
  output logic            eof2_marker
);
  logic [7:0]      line2;
  logic [7:0]      line3;
  logic [7:0]      susp_en;
  logic [3:1][7:0] flags;
  logic [2:0]      eof_cnt;
  wire  [1:0]      idx      = dev_req.addr[1:0] + 2'h1;
  wire             flag_hit = dev_req.addr[DEV_AW-1:2] == PORT1_CHANGE_ADDR[DEV_AW-1:2] && idx != 2'h0;
  // Firmware may only set bit 3 of ports 2 and 3 and bit 2 of port 1; other flags it can only clear.
  wire  [7:0]      settable = (idx == 2'h1) ? 8'h04 : 8'h08;
  wire  [7:0]      next_flags = ((flags[idx] & dev_req.wdata) | (dev_req.wdata & settable)) & 8'h1F;
  wire             conn2 = (port2_lines != 2'h0) != (line2[1:0] != 2'h0);
  wire             conn3 = (port3_lines != 2'h0) != (line3[1:0] != 2'h0);
  wire  [7:0]      rd_mux = (dev_req.addr == PORT2_LINE_STATE_ADDR) ? line2 :
                            (dev_req.addr == PORT3_LINE_STATE_ADDR) ? line3 :
                            (dev_req.addr == SUSP_OC_ENABLE_ADDR) ? susp_en :
                            flag_hit ? flags[idx] : 8'h00;
  assign eof2_marker = eof_cnt != 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line2     <= 8'h00;
      line3     <= 8'h00;
      susp_en   <= 8'h00;
      flags     <= '0;
      eof_cnt   <= 3'h0;
      dev_rdata <= 8'h00;
    end else begin
      if (frame_end) begin
        eof_cnt <= 3'h4;
      end else if (eof_cnt != 3'h0) begin
        eof_cnt <= eof_cnt - 3'h1;
      end
      if (dev_req.wr && flag_hit) begin
        flags[idx] <= next_flags;
      end
      if (dev_req.wr && dev_req.addr == SUSP_OC_ENABLE_ADDR) begin
        susp_en <= dev_req.wdata & 8'h0C;
      end
      // Hardware sets land after the firmware write so a same-cycle clear loses.
      if (frame_end) begin
        line2 <= {6'h00, port2_lines};
        line3 <= {6'h00, port3_lines};
        if (conn2) begin
          flags[2][0] <= 1'b1;
        end
        if (conn3) begin
          flags[3][0] <= 1'b1;
        end
      end
      // Read data is only good for one cycle; afterwards the bus shows junk.
      if (dev_req.rd) begin
        dev_rdata <= rd_mux;
      end else begin
        dev_rdata <= ~dev_rdata;
      end
    end
  end
endmodule

// ==== sim/test_hub_power_manager.sv ====
`timescale 1ns/1ns
module test_hub_power_manager import hub_power_pkg::*;;
  localparam int RES_DLY = 50;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  dev_req_t    dev_req;
  logic [7:0]  dev_rdata;
  logic        general_input_d0 = 1'b1;
  logic        general_input_d1 = 1'b1;
  logic        eof2_marker;
  logic        shared_power_switch_control_n;
  logic        port2_power_switch_control_n;
  logic        port3_power_switch_control_n;
  logic [1:0]  port2_lines = 2'h0;
  logic [1:0]  port3_lines = 2'h0;
  logic        frame_end = 1'b0;
  int          bad_count = 0;
  int          n_tests = 0;
  wire  [31:0] pins = {29'h0, shared_power_switch_control_n, port2_power_switch_control_n, port3_power_switch_control_n};

  hub_power_manager #(.RESUME_DELAY(RES_DLY)) DUT (.*);
  hub_device_model u_dev (.*);

  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic       done;
    done = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er,
                    output logic [31:0] d);
    logic [1:0] r;
    logic       done;
    done = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk({30'h0, r}, {30'h0, er});
    chk(d & m, e);
    @(posedge aclk);
  endtask

  // Fault pins pass a three-stage synchroniser, so give them a few cycles before polling busy.
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h400;
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 30 && s[10] === 1'b1; i++) begin
      rd(STATUS_OFFSET, 32'h0, 32'h0, RESP_OKAY, s);
    end
    chk({31'h0, s[10]}, 32'h0);
  endtask

  task automatic set_ctrl(input logic [31:0] c, input logic [31:0] p);
    axi_wr(CTRL_OFFSET, c, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(pins, p);
  endtask

  task automatic pulse_frame;
    frame_end <= 1'b1;
    @(posedge aclk);
    frame_end <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] clr(input logic [1:0] p, input logic [4:0] m);
    return (32'h1 << CMD_CLEAR) | ({27'h0, m} << CMD_MASK_LSB) | {30'h0, p};
  endfunction

  task automatic t_reset;
    logic [31:0] d;
    chk(pins, 32'h7);
    rd(CTRL_OFFSET, 32'hFFFFFFFF, 32'h0, RESP_OKAY, d);
    rd(STATUS_OFFSET, 32'h7FF, 32'h20, RESP_OKAY, d);
    rd(CMD_OFFSET, 32'hFFFFFFFF, 32'h0, RESP_OKAY, d);
    rd(4'hC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, d);
    axi_wr(STATUS_OFFSET, 32'hFFFFFFFF, RESP_SLVERR);
  endtask

  task automatic t_switching;
    set_ctrl(32'h04, 32'h3);
    set_ctrl(32'h0C, 32'h3);
    set_ctrl(32'h08, 32'h3);
    set_ctrl(32'h00, 32'h7);
    set_ctrl(32'h06, 32'h5);
    set_ctrl(32'h0A, 32'h6);
    set_ctrl(32'h0E, 32'h4);
    set_ctrl(32'h02, 32'h7);
  endtask

  task automatic t_lines;
    logic [31:0] d;
    port2_lines <= 2'h2;
    port3_lines <= 2'h1;
    pulse_frame;
    axi_wr(CMD_OFFSET, 32'h1 << CMD_CAPTURE, RESP_OKAY);
    wait_idle;
    rd(STATUS_OFFSET, 32'h7FF, 32'h26, RESP_OKAY, d);
    axi_wr(CMD_OFFSET, clr(2'h2, 5'h01), RESP_OKAY);
    wait_idle;
    chk({24'h0, u_dev.flags[2]}, 32'h0);
    chk({24'h0, u_dev.flags[3]}, 32'h1);
    port2_lines <= 2'h1;
    port3_lines <= 2'h2;
    pulse_frame;
    axi_wr(CMD_OFFSET, 32'h1 << CMD_CAPTURE, RESP_OKAY);
    wait_idle;
    rd(STATUS_OFFSET, 32'h7FF, 32'h29, RESP_OKAY, d);
  endtask

  task automatic t_port_oc;
    logic [31:0] d;
    set_ctrl(32'h0F, 32'h4);
    general_input_d0 <= 1'b0;
    wait_idle;
    rd(CTRL_OFFSET, 32'h1F, 32'h0B, RESP_OKAY, d);
    chk(pins, 32'h6);
    rd(STATUS_OFFSET, 32'h3C0, 32'h100, RESP_OKAY, d);
    chk({31'h0, u_dev.flags[2][3]}, 32'h1);
    general_input_d1 <= 1'b0;
    wait_idle;
    rd(CTRL_OFFSET, 32'h1F, 32'h03, RESP_OKAY, d);
    chk(pins, 32'h7);
    rd(STATUS_OFFSET, 32'h3C0, 32'h300, RESP_OKAY, d);
    chk({31'h0, u_dev.flags[3][3]}, 32'h1);
    general_input_d0 <= 1'b1;
    general_input_d1 <= 1'b1;
    axi_wr(CMD_OFFSET, 32'h1 << CMD_OC_RELEASE, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h3C0, 32'h0, RESP_OKAY, d);
    for (int p = 2; p <= 3; p++) begin
      axi_wr(CMD_OFFSET, clr(2'(p), 5'h08), RESP_OKAY);
      wait_idle;
    end
    chk({30'h0, u_dev.flags[2][3], u_dev.flags[3][3]}, 32'h0);
  endtask

  task automatic t_global_oc;
    logic [31:0] d;
    set_ctrl(32'h0C, 32'h3);
    general_input_d1 <= 1'b0;
    wait_idle;
    rd(CTRL_OFFSET, 32'h1F, 32'h0C, RESP_OKAY, d);
    general_input_d0 <= 1'b0;
    wait_idle;
    rd(CTRL_OFFSET, 32'h1F, 32'h00, RESP_OKAY, d);
    chk(pins, 32'h7);
    rd(STATUS_OFFSET, 32'h3C0, 32'h0C0, RESP_OKAY, d);
    chk({30'h0, u_dev.flags[2][3], u_dev.flags[3][3]}, 32'h0);
    general_input_d0 <= 1'b1;
    general_input_d1 <= 1'b1;
    axi_wr(CMD_OFFSET, 32'h1 << CMD_HUB_OC_ACK, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h3C0, 32'h040, RESP_OKAY, d);
    axi_wr(CMD_OFFSET, 32'h1 << CMD_OC_RELEASE, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h3C0, 32'h0, RESP_OKAY, d);
  endtask

  task automatic t_suspend;
    logic [31:0] cv [3];
    logic [7:0]  ev [3];
    cv = '{32'h10, 32'h11, 32'h00};
    ev = '{8'h04, 8'h0C, 8'h00};
    for (int i = 0; i < 3; i++) begin
      set_ctrl(cv[i], 32'h7);
      wait_idle;
      chk({24'h0, u_dev.susp_en}, {24'h0, ev[i]});
    end
  endtask

  task automatic t_resume;
    axi_wr(CMD_OFFSET, 32'h1 << CMD_P1_RESUMED, RESP_OKAY);
    repeat (10) @(posedge aclk);
    pulse_frame;
    repeat (RES_DLY - 10) @(posedge aclk);
    chk({24'h0, u_dev.flags[1]}, 32'h0);
    repeat (30) @(posedge aclk);
    wait_idle;
    chk({24'h0, u_dev.flags[1]}, 32'h4);
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_switching;
    t_lines;
    t_port_oc;
    t_global_oc;
    t_suspend;
    t_resume;
    test_done;
  end

  // The whole run needs a few hundred cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("Watchdog expired");
    test_done;
  end
endmodule
